// ### src/tec_ctrl.sv
// Timer 0 and external interrupt control register with AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`include "tec_regs.svh"

module tec_ctrl #(
	parameter int ADDR_W = 8
) (
	// Clock, reset and clock enable
	input  wire logic                  sys_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  ce,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	// AXI4-Lite write response
	output tec_pkg::tec_resp_t         s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0]     s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output tec_pkg::tec_resp_t         s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// Timer 0 side
	input  wire logic                  tmr_a_ovf_evt,
	input  wire logic                  tmr_a_vector_ack,
	output logic                       tmr_a_run,
	output logic                       tmr_a_overflow_flag,
	// External interrupt pins and polarity from pin config
	input  wire logic                  xirq_a_input,
	input  wire logic                  xirq_b_input,
	input  wire logic                  xirq_a_polarity,
	input  wire logic                  xirq_b_polarity,
	// Core vectoring and pending flags
	input  wire logic                  xirq_a_vector_ack,
	input  wire logic                  xirq_b_vector_ack,
	output logic                       xirq_a_pending,
	output logic                       xirq_b_pending,
	output logic                       xirq_a_type_sel,
	output logic                       xirq_b_type_sel
);
	import tec_pkg::*;

	// Field positions per interrupt channel, A first
	localparam int PEND_POS [2] = '{`TEC_XA_PEND_BIT, `TEC_XB_PEND_BIT};
	localparam int TYPE_POS [2] = '{`TEC_XA_TYPE_BIT, `TEC_XB_TYPE_BIT};
	// Address decode shared by read and write paths
	function automatic tec_sel_t tec_decode(input logic [ADDR_W-1:0] a);
		tec_decode = (8'(a) == `TEC_CTRL_OFS) ? TEC_SEL_CTRL
			: (8'(a) == `TEC_STAT_OFS) ? TEC_SEL_STAT : TEC_SEL_NONE;
	endfunction
	// Pin level turned into active/inactive by polarity, 1 = high
	function automatic logic tec_active(input logic lvl, input logic pol);
		tec_active = ~(lvl ^ pol);
	endfunction

	// Register state
	logic [5:0]         ctrl_r;
	logic [5:0]         ctrl_nxt;
	logic [1:0]         sync1_r;
	logic [1:0]         sync2_r;
	logic [1:0]         sync3_r;
	logic [1:0]         filt_r;
	logic [1:0]         filt_nxt;
	logic [1:0]         act_prev_r;
	logic [1:0]         act_w;
	logic [1:0]         edge_w;
	logic [1:0]         vec_w;
	logic [1:0]         pol_w;
	// Write channel state
	tec_wr_st_t         wr_st_r;
	tec_wr_st_t         wr_st_nxt;
	logic               aw_got_r;
	logic               aw_got_nxt;
	logic               w_got_r;
	logic               w_got_nxt;
	logic [ADDR_W-1:0]  waddr_r;
	logic [ADDR_W-1:0]  waddr_nxt;
	logic [31:0]        wdata_r;
	logic [31:0]        wdata_nxt;
	logic [3:0]         wstrb_r;
	logic [3:0]         wstrb_nxt;
	tec_resp_t          bresp_r;
	tec_resp_t          bresp_nxt;
	logic               aw_take;
	logic               w_take;
	logic               wr_do;
	logic               wr_ctrl;
	logic [ADDR_W-1:0]  wr_addr;
	logic [31:0]        wr_data;
	logic [3:0]         wr_strb;
	// Read channel state
	tec_rd_st_t         rd_st_r;
	tec_rd_st_t         rd_st_nxt;
	logic [31:0]        rdata_r;
	logic [31:0]        rdata_nxt;
	tec_resp_t          rresp_r;
	tec_resp_t          rresp_nxt;
	// Combinational views of pins and acks per channel
	assign pol_w = {xirq_b_polarity, xirq_a_polarity};
	assign vec_w = {xirq_b_vector_ack, xirq_a_vector_ack};
	// Filter on stages two and three, then active level and edge
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			if (sync2_r[i] == sync3_r[i])
				filt_nxt[i] = sync3_r[i];
			else
				filt_nxt[i] = filt_r[i];
			act_w[i]  = tec_active(filt_r[i], pol_w[i]);
			edge_w[i] = act_w[i] & ~act_prev_r[i];
		end
	end

	// Pin synchronisers, filter and previous active level
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sync1_r    <= `TEC_SYNC_RST;
			sync2_r    <= `TEC_SYNC_RST;
			sync3_r    <= `TEC_SYNC_RST;
			filt_r     <= `TEC_SYNC_RST;
			act_prev_r <= `TEC_SYNC_RST;
		end else if (ce) begin
			sync1_r    <= {xirq_b_input, xirq_a_input};
			sync2_r    <= sync1_r;
			sync3_r    <= sync2_r;
			filt_r     <= filt_nxt;
			act_prev_r <= act_w;
		end
	end

	// Write channel handshake; address and data in either order
	assign s_axi_awready = ce & (wr_st_r == TEC_WR_IDLE) & ~aw_got_r;
	assign s_axi_wready  = ce & (wr_st_r == TEC_WR_IDLE) & ~w_got_r;
	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take  = s_axi_wvalid & s_axi_wready;
	assign wr_addr = aw_got_r ? waddr_r : s_axi_awaddr;
	assign wr_data = w_got_r ? wdata_r : s_axi_wdata;
	assign wr_strb = w_got_r ? wstrb_r : s_axi_wstrb;
	assign wr_do   = (aw_got_r | aw_take) & (w_got_r | w_take);
	assign wr_ctrl = wr_do & (tec_decode(wr_addr) == TEC_SEL_CTRL)
		& wr_strb[0];
	// Write channel next state
	always_comb begin
		wr_st_nxt  = wr_st_r;
		aw_got_nxt = aw_got_r | aw_take;
		w_got_nxt  = w_got_r | w_take;
		waddr_nxt  = aw_take ? s_axi_awaddr : waddr_r;
		wdata_nxt  = w_take ? s_axi_wdata : wdata_r;
		wstrb_nxt  = w_take ? s_axi_wstrb : wstrb_r;
		bresp_nxt  = bresp_r;
		case (wr_st_r)
			TEC_WR_IDLE: begin
				if (wr_do) begin
					aw_got_nxt = 1'b0;
					w_got_nxt  = 1'b0;
					wr_st_nxt  = TEC_WR_RESP;
					bresp_nxt  = (tec_decode(wr_addr) == TEC_SEL_NONE)
						? TEC_RESP_SLVERR : TEC_RESP_OKAY;
				end
			end
			TEC_WR_RESP: begin
				if (s_axi_bready)
					wr_st_nxt = TEC_WR_IDLE;
			end
			default: wr_st_nxt = TEC_WR_IDLE;
		endcase
	end
	// Write channel registers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wr_st_r  <= TEC_WR_IDLE;
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			waddr_r  <= '0;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
			bresp_r  <= TEC_RESP_OKAY;
		end else if (ce) begin
			wr_st_r  <= wr_st_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r  <= w_got_nxt;
			waddr_r  <= waddr_nxt;
			wdata_r  <= wdata_nxt;
			wstrb_r  <= wstrb_nxt;
			bresp_r  <= bresp_nxt;
		end
	end
	// Write response outputs
	assign s_axi_bvalid = (wr_st_r == TEC_WR_RESP);
	assign s_axi_bresp  = bresp_r;
	// Control register: software write, then vector clear, then set
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl)
			ctrl_nxt = wr_data[5:0];
		if (tmr_a_vector_ack)
			ctrl_nxt[`TEC_TMR_OVF_BIT] = 1'b0;
		if (tmr_a_ovf_evt)
			ctrl_nxt[`TEC_TMR_OVF_BIT] = 1'b1;
		for (int i = 0; i < 2; i++) begin
			if (ctrl_r[TYPE_POS[i]] == `TEC_TYPE_EDGE) begin
				if (vec_w[i])
					ctrl_nxt[PEND_POS[i]] = 1'b0;
				if (edge_w[i])
					ctrl_nxt[PEND_POS[i]] = 1'b1;
			end else begin
				ctrl_nxt[PEND_POS[i]] = act_w[i];
			end
		end
	end
	// Control register storage
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			ctrl_r <= `TEC_CTRL_RST;
		else if (ce)
			ctrl_r <= ctrl_nxt;
	end
	// Field outputs straight from the control register
	assign tmr_a_overflow_flag = ctrl_r[`TEC_TMR_OVF_BIT];
	assign tmr_a_run           = ctrl_r[`TEC_TMR_RUN_BIT];
	assign xirq_b_pending      = ctrl_r[`TEC_XB_PEND_BIT];
	assign xirq_b_type_sel     = ctrl_r[`TEC_XB_TYPE_BIT];
	assign xirq_a_pending      = ctrl_r[`TEC_XA_PEND_BIT];
	assign xirq_a_type_sel     = ctrl_r[`TEC_XA_TYPE_BIT];
	// Read channel: one read at a time, data latched when taken
	assign s_axi_arready = ce & (rd_st_r == TEC_RD_IDLE);
	always_comb begin
		rd_st_nxt = rd_st_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		case (rd_st_r)
			TEC_RD_IDLE: begin
				if (s_axi_arvalid) begin
					rd_st_nxt = TEC_RD_DATA;
					rresp_nxt = TEC_RESP_OKAY;
					case (tec_decode(s_axi_araddr))
						TEC_SEL_CTRL: rdata_nxt = {26'h0, ctrl_r};
						TEC_SEL_STAT: rdata_nxt = {28'h0, act_w, filt_r};
						default: begin
							rdata_nxt = 32'h0000_0000;
							rresp_nxt = TEC_RESP_SLVERR;
						end
					endcase
				end
			end
			TEC_RD_DATA: begin
				if (s_axi_rready)
					rd_st_nxt = TEC_RD_IDLE;
			end
			default: rd_st_nxt = TEC_RD_IDLE;
		endcase
	end

	// Read channel registers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rd_st_r <= TEC_RD_IDLE;
			rdata_r <= 32'h0000_0000;
			rresp_r <= TEC_RESP_OKAY;
		end else if (ce) begin
			rd_st_r <= rd_st_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end
	// Read response outputs
	assign s_axi_rvalid = (rd_st_r == TEC_RD_DATA);
	assign s_axi_rdata  = rdata_r;
	assign s_axi_rresp  = rresp_r;

	// Checks on flag behaviour and bus handshakes
	default clocking tec_cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	a_tmr_ovf_set: assert property (
		ce && tmr_a_ovf_evt |=> tmr_a_overflow_flag
	) else $error("overflow event did not set flag");
	a_tmr_ovf_clr: assert property (
		ce && tmr_a_vector_ack && !tmr_a_ovf_evt |=> !tmr_a_overflow_flag
	) else $error("vectoring did not clear overflow flag");
	a_tmr_run_wr: assert property (
		ce && wr_ctrl |=> tmr_a_run == $past(wr_data[`TEC_TMR_RUN_BIT])
	) else $error("run bit does not match written value");
	a_xb_edge_set: assert property (
		ce && xirq_b_type_sel && edge_w[1] |=> xirq_b_pending
	) else $error("interrupt B edge did not set pending");
	a_xb_vec_clr: assert property (
		ce && xirq_b_type_sel && xirq_b_vector_ack && !edge_w[1]
		|=> !xirq_b_pending
	) else $error("interrupt B vectoring did not clear pending");
	a_xb_level: assert property (
		ce && !xirq_b_type_sel |=> xirq_b_pending == $past(act_w[1])
	) else $error("interrupt B level flag does not follow pin");
	a_xa_edge_set: assert property (
		ce && xirq_a_type_sel && edge_w[0] |=> xirq_a_pending
	) else $error("interrupt A edge did not set pending");
	a_xa_vec_clr: assert property (
		ce && xirq_a_type_sel && xirq_a_vector_ack && !edge_w[0]
		|=> !xirq_a_pending
	) else $error("interrupt A vectoring did not clear pending");
	a_xa_level: assert property (
		ce && !xirq_a_type_sel |=> xirq_a_pending == $past(act_w[0])
	) else $error("interrupt A level flag does not follow pin");
	a_pin_filter: assert property (
		ce |=> ((filt_r ^ $past(filt_r))
			& ($past(sync2_r) ^ $past(sync3_r))) == 2'h0
	) else $error("filter moved while stages disagree");
	a_bus_bhold: assert property (
		s_axi_bvalid && !(ce && s_axi_bready) |=> s_axi_bvalid
	) else $error("write response dropped before taken");
	a_bus_rhold: assert property (
		s_axi_rvalid && !(ce && s_axi_rready)
		|=> s_axi_rvalid && $stable(s_axi_rdata)
	) else $error("read data dropped before taken");

endmodule // tec_ctrl

// ### inc/tec_regs.svh
// Register offsets, field positions, reset values and type select encoding
`ifndef TEC_REGS_SVH
`define TEC_REGS_SVH

// Byte offsets of the two registers
`define TEC_CTRL_OFS     8'h00
`define TEC_STAT_OFS     8'h04

// Control register field positions
`define TEC_TMR_OVF_BIT  5
`define TEC_TMR_RUN_BIT  4
`define TEC_XB_PEND_BIT  3
`define TEC_XB_TYPE_BIT  2
`define TEC_XA_PEND_BIT  1
`define TEC_XA_TYPE_BIT  0

// Reset values
`define TEC_CTRL_RST     6'h00
`define TEC_SYNC_RST     2'h0

// Type select encoding
`define TEC_TYPE_LEVEL   1'b0
`define TEC_TYPE_EDGE    1'b1

`endif

// ### inc/tec_pkg.sv
// Types shared by the timer and external interrupt control block
package tec_pkg;

	// Bus response codes
	typedef enum logic [1:0] {
		TEC_RESP_OKAY   = 2'h0,
		TEC_RESP_SLVERR = 2'h2
	} tec_resp_t;

	// Write channel states, one-hot
	typedef enum logic [1:0] {
		TEC_WR_IDLE = 2'b01,
		TEC_WR_RESP = 2'b10
	} tec_wr_st_t;

	// Read channel states, one-hot
	typedef enum logic [1:0] {
		TEC_RD_IDLE = 2'b01,
		TEC_RD_DATA = 2'b10
	} tec_rd_st_t;

	// Register select from address decode
	typedef enum logic [1:0] {
		TEC_SEL_NONE = 2'h0,
		TEC_SEL_CTRL = 2'h1,
		TEC_SEL_STAT = 2'h2
	} tec_sel_t;

endpackage

// ### sim/tec_core_model.sv
// Core vectoring model that acknowledges raised flags after a set latency
module tec_core_model (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	// Service control from the bench
	input  wire logic [2:0] serve_en,
	input  wire logic [1:0] serve_lat,
	// Flags seen and vector acknowledges
	input  wire logic [2:0] flag,
	output logic      [2:0] ack
);
	logic [1:0] cnt [3];
	logic [2:0] busy;

	// One vector pulse per raised flag, then wait for it to drop
	always @(posedge sys_clk) begin
		for (int i = 0; i < 3; i++) begin
			ack[i] <= 1'h0;
			if (sys_rst || !serve_en[i] || !flag[i]) begin
				cnt[i] <= 2'h0;
				busy[i] <= 1'h0;
			end else if (!busy[i]) begin
				if (cnt[i] == serve_lat) begin
					ack[i] <= 1'h1;
					busy[i] <= 1'h1;
				end else begin
					cnt[i] <= cnt[i] + 2'h1;
				end
			end
		end
	end
endmodule // tec_core_model

// ### sim/tb.sv
// Self-checking testbench for the timer and interrupt control block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tec_pkg::*;

	logic        sys_clk = 1'h0;
	logic        sys_rst = 1'h1;
	logic        ce = 1'h1;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hF;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic        arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] rdata;
	tec_resp_t   bresp, rresp;
	logic        ovf = 1'h0, xa_in = 1'h0, xb_in = 1'h0;
	logic        xa_pol = 1'h1, xb_pol = 1'h1;
	logic [2:0]  serve_en = 3'h0, ack;
	logic [1:0]  serve_lat = 2'h0, rs;
	logic        run, ovf_flag, xa_pend, xb_pend, xa_type, xb_type;
	int          error_cnt = 0, tests_run = 0, cyc = 0, m_ctrl = 0;

	always #20 sys_clk = ~sys_clk;

	tec_ctrl u_tec_ctrl (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.tmr_a_ovf_evt(ovf), .tmr_a_vector_ack(ack[0]),
		.tmr_a_run(run), .tmr_a_overflow_flag(ovf_flag),
		.xirq_a_input(xa_in), .xirq_b_input(xb_in),
		.xirq_a_polarity(xa_pol), .xirq_b_polarity(xb_pol),
		.xirq_a_vector_ack(ack[1]), .xirq_b_vector_ack(ack[2]),
		.xirq_a_pending(xa_pend), .xirq_b_pending(xb_pend),
		.xirq_a_type_sel(xa_type), .xirq_b_type_sel(xb_type)
	);

	tec_core_model u_tec_core_model (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .serve_en(serve_en),
		.serve_lat(serve_lat), .flag({xb_pend, xa_pend, ovf_flag}),
		.ack(ack)
	);

	// Verdict and end of run
	task automatic conclude();
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Write with both channels offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s, output logic [1:0] r);
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'h0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
			input logic [1:0] er);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		chk(rdata, e);
		chk(32'(rresp), 32'(er));
		rready <= 1'h0;
	endtask

	// Control write that also updates the model
	task automatic wrm(input logic [31:0] d);
		wr(8'h00, d, 4'hF, rs);
		chk(32'(rs), 32'h0);
		m_ctrl = int'(d[5:0]);
	endtask

	task automatic pulse_ovf();
		tick(1);
		ovf <= 1'h1;
		tick(1);
		ovf <= 1'h0;
		tick(1);
	endtask

	task automatic serve(input int i);
		tick(1);
		serve_lat <= 2'($urandom_range(3));
		serve_en[i] <= 1'h1;
		tick(8);
		serve_en <= 3'h0;
	endtask

	task automatic set_pin(input int i, input logic v);
		tick(1);
		if (i == 1) xb_in <= v;
		else xa_in <= v;
		tick(7);
	endtask

	// Main sequence
	initial begin
		void'($urandom(32'h9BB451C8));
		tick(20);
		sys_rst <= 1'h0;
		tick(8);
		rdchk(8'h00, 32'h0, 2'h0);
		rdchk(8'h08, 32'h0, 2'h2);
		wrm(($urandom() & 32'hFFFFFFC0) | 32'h15);
		chk(32'(run), 32'h1);
		chk(32'({xb_type, xa_type}), 32'h3);
		rdchk(8'h00, 32'h15, 2'h0);
		wr(8'h08, 32'h3F, 4'hF, rs);
		chk(32'(rs), 32'h2);
		wr(8'h04, 32'h3F, 4'hF, rs);
		chk(32'(rs), 32'h0);
		wr(8'h00, 32'h0, 4'hE, rs);
		chk(32'(rs), 32'h0);
		rdchk(8'h00, 32'h15, 2'h0);
		pulse_ovf();
		chk(32'(ovf_flag), 32'h1);
		rdchk(8'h00, 32'h35, 2'h0);
		wrm(32'h15);
		chk(32'(ovf_flag), 32'h0);
		pulse_ovf();
		serve(0);
		chk(32'(ovf_flag), 32'h0);
		// Clock enable low: readies drop and the flag ignores events
		ce <= 1'h0;
		pulse_ovf();
		chk(32'({awready, wready, arready, ovf_flag}), 32'h0);
		ce <= 1'h1;
		// Edge mode: set on pin edge, cleared by vectoring, not set again by the pin going inactive
		for (int i = 0; i < 2; i++) begin
			set_pin(i, 1'h1);
			chk(32'({xb_pend, xa_pend}), i + 1);
			rdchk(8'h00, m_ctrl | (i == 1 ? 8 : 2), 2'h0);
			serve(i + 1);
			rdchk(8'h00, m_ctrl, 2'h0);
			set_pin(i, 1'h0);
			rdchk(8'h00, m_ctrl, 2'h0);
		end
		// Level mode follows the active level of each pin
		wrm(32'h10);
		set_pin(0, 1'h1);
		set_pin(1, 1'h1);
		rdchk(8'h00, 32'h1A, 2'h0);
		rdchk(8'h04, 32'hF, 2'h0);
		serve(1);
		rdchk(8'h00, 32'h1A, 2'h0);
		xa_pol <= 1'h0;
		xb_pol <= 1'h0;
		tick(8);
		rdchk(8'h00, 32'h10, 2'h0);
		rdchk(8'h04, 32'h3, 2'h0);
		set_pin(0, 1'h0);
		set_pin(1, 1'h0);
		rdchk(8'h00, 32'h1A, 2'h0);
		wrm(32'h00);
		chk(32'(run), 32'h0);
		conclude();
	end
endmodule // tb
